// ### logic/cbtm_ctrl.sv
// The implementer's own choices: the address map and the plain strobed port.
`include "cbtm_consts.svh"

module cbtm_ctrl
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic [`CBTM_ADDR_W-1:0] reg_addr,
    input  wire cbtm_pkg::cbtm_byte_t    reg_wr_data,
    input  wire logic                    reg_wr_en,
    input  wire logic                    reg_rd_en,
    output cbtm_pkg::cbtm_byte_t         reg_rd_data,
    input  wire logic                    osc_clk_pin,
    input  wire logic                    rx_pin,
    output logic                         tx_pin,
    output logic                         init_mode,
    output logic                         sleep_mode,
    output logic                         tq_tick,
    output logic                         bit_start,
    output logic                         bit_valid,
    output logic                         bit_value
);
    import cbtm_pkg::*;

    localparam logic [7:0] WAKE_CYC = 8'(`CBTM_WAKE_PULSE_CYC);

    logic       init_request_q;
    logic       sleep_request_q;
    logic       wake_enable_q;
    logic       wake_flag_q;
    logic       init_ack_q;
    logic       sleep_ack_q;
    logic       module_enable_q;
    logic       can_clock_select_q;
    logic [2:0] ctl1_misc_q;
    logic       wake_filter_select_q;
    cbtm_byte_t btr0_q;
    cbtm_byte_t btr1_q;
    cbtm_byte_t acc_ctl_q;
    cbtm_byte_t acc_code_q [0:`CBTM_ACC_REGS-1];
    cbtm_byte_t acc_mask_q [0:`CBTM_ACC_REGS-1];
    cbtm_byte_t rd_data_q;
    logic [1:0] osc_sync_q;
    logic       osc_prev_q;
    logic [1:0] rx_sync_q;
    logic [7:0] wake_cnt_q;
    logic       tx_q;
    logic       init_mode_q;
    logic       sleep_mode_q;

    logic       init_active;
    logic       sleep_active;
    logic       osc_en;
    logic       can_clk_en;
    logic       rx_s;
    logic       wake_hit;
    logic       wr_ctl0;
    logic       cfg_wr;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and CAN clock enable

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_sync_q <= 2'h0;
            osc_prev_q <= 1'b0;
            rx_sync_q  <= 2'h3;
        end
        else
        begin
            osc_sync_q <= {osc_sync_q[0], osc_clk_pin};
            osc_prev_q <= osc_sync_q[1];
            rx_sync_q  <= {rx_sync_q[0], rx_pin};
        end
    end

    // Oscillator must run below a quarter of sys_clk to be seen edge by edge
    assign osc_en     = osc_sync_q[1] & ~osc_prev_q;
    assign can_clk_en = can_clock_select_q ? 1'b1 : osc_en;
    assign rx_s       = rx_sync_q[1];

    assign init_active  = init_request_q & init_ack_q;
    assign sleep_active = sleep_request_q & sleep_ack_q;

    ////////////////////////////////////////////////////////////////////////////
    // Wake-up detection

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_cnt_q <= 8'h00;
        end
        else if (!sleep_active || rx_s)
        begin
            wake_cnt_q <= 8'h00;
        end
        else if (wake_cnt_q != WAKE_CYC)
        begin
            wake_cnt_q <= wake_cnt_q + 8'h01;
        end
    end

    // Filter counts sys_clk cycles of steady dominant level
    assign wake_hit = sleep_active & wake_enable_q & ~rx_s
                    & (~wake_filter_select_q | (wake_cnt_q == WAKE_CYC));

    ////////////////////////////////////////////////////////////////////////////
    // Mode request register and handshake

    assign wr_ctl0 = reg_wr_en && reg_addr == `CBTM_OFF_CTL0;
    assign cfg_wr  = reg_wr_en && init_active;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            init_request_q  <= 1'(`CBTM_RST_CTL0 >> `CBTM_CTL0_INIT_REQ);
            sleep_request_q <= 1'b0;
            wake_enable_q   <= 1'b0;
        end
        else
        begin
            if (wr_ctl0)
            begin
                wake_enable_q <= reg_wr_data[`CBTM_CTL0_WAKE_EN];
                if (reg_wr_data[`CBTM_CTL0_INIT_REQ] || init_active)
                begin
                    init_request_q <= reg_wr_data[`CBTM_CTL0_INIT_REQ];
                end
            end
            // Wake clears the request so the block does not fall asleep again
            if (wake_hit)
            begin
                sleep_request_q <= 1'b0;
            end
            else if (wr_ctl0 && (reg_wr_data[`CBTM_CTL0_SLEEP_REQ] || sleep_active))
            begin
                sleep_request_q <= reg_wr_data[`CBTM_CTL0_SLEEP_REQ];
            end
        end
    end

    // Wake flag: write one clears, a new wake in the same cycle wins
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_flag_q <= 1'b0;
        end
        else if (wake_hit)
        begin
            wake_flag_q <= 1'b1;
        end
        else if (wr_ctl0 && reg_wr_data[`CBTM_CTL0_WAKE_FLAG])
        begin
            wake_flag_q <= 1'b0;
        end
    end

    // Acks move on the CAN clock enable, so a slow oscillator delays them; a wake clears the sleep ack at once
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            init_ack_q  <= 1'b0;
            sleep_ack_q <= 1'b0;
        end
        else
        begin
            if (can_clk_en)
            begin
                init_ack_q <= init_request_q;
            end
            if (wake_hit)
            begin
                sleep_ack_q <= 1'b0;
            end
            else if (can_clk_en)
            begin
                // Enter sleep only on an idle (recessive) bus
                if (!sleep_request_q)
                begin
                    sleep_ack_q <= 1'b0;
                end
                else if (rx_s && !sleep_ack_q)
                begin
                    sleep_ack_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers, writable in init mode only

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            module_enable_q      <= 1'b0;
            can_clock_select_q   <= 1'b0;
            ctl1_misc_q          <= 3'h0;
            wake_filter_select_q <= 1'b0;
        end
        else if (cfg_wr && reg_addr == `CBTM_OFF_CTL1)
        begin
            module_enable_q      <= reg_wr_data[`CBTM_CTL1_ENABLE];
            can_clock_select_q   <= reg_wr_data[`CBTM_CTL1_CLK_SEL];
            ctl1_misc_q          <= reg_wr_data[5:3];
            wake_filter_select_q <= reg_wr_data[`CBTM_CTL1_WAKE_FILT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            btr0_q    <= `CBTM_RST_BTR0;
            btr1_q    <= `CBTM_RST_BTR1;
            acc_ctl_q <= `CBTM_RST_ACC;
        end
        else if (cfg_wr)
        begin
            if (reg_addr == `CBTM_OFF_BTR0)
            begin
                btr0_q <= reg_wr_data;
            end
            if (reg_addr == `CBTM_OFF_BTR1)
            begin
                btr1_q <= reg_wr_data;
            end
            if (reg_addr == `CBTM_OFF_ACC_CTL)
            begin
                acc_ctl_q <= reg_wr_data;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `CBTM_ACC_REGS; gi++)
        begin : g_acc
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    acc_code_q[gi] <= `CBTM_RST_ACC;
                    acc_mask_q[gi] <= `CBTM_RST_ACC;
                end
                else if (cfg_wr)
                begin
                    if (reg_addr == `CBTM_OFF_ACC_CODE + 5'(gi))
                    begin
                        acc_code_q[gi] <= reg_wr_data;
                    end
                    if (reg_addr == `CBTM_OFF_ACC_MASK + 5'(gi))
                    begin
                        acc_mask_q[gi] <= reg_wr_data;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read port: data one cycle after the strobe, zero elsewhere

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_q <= 8'h00;
        end
        else if (!reg_rd_en)
        begin
            rd_data_q <= 8'h00;
        end
        else if (reg_addr == `CBTM_OFF_CTL0)
        begin
            rd_data_q <= {wake_flag_q, 4'h0, wake_enable_q, sleep_request_q, init_request_q};
        end
        else if (reg_addr == `CBTM_OFF_CTL1)
        begin
            rd_data_q <= {module_enable_q, can_clock_select_q, ctl1_misc_q,
                          wake_filter_select_q, sleep_ack_q, init_ack_q};
        end
        else if (reg_addr == `CBTM_OFF_BTR0)
        begin
            rd_data_q <= btr0_q;
        end
        else if (reg_addr == `CBTM_OFF_BTR1)
        begin
            rd_data_q <= btr1_q;
        end
        else if (reg_addr == `CBTM_OFF_ACC_CTL)
        begin
            rd_data_q <= acc_ctl_q;
        end
        else if (reg_addr[4:3] == 2'h1)
        begin
            rd_data_q <= acc_code_q[reg_addr[2:0]];
        end
        else if (reg_addr[4:3] == 2'h2)
        begin
            rd_data_q <= acc_mask_q[reg_addr[2:0]];
        end
        else
        begin
            rd_data_q <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode outputs; transmit held recessive since no transmitter lives here

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_q         <= 1'b1;
            init_mode_q  <= 1'b0;
            sleep_mode_q <= 1'b0;
        end
        else
        begin
            tx_q         <= 1'b1;
            init_mode_q  <= init_active;
            sleep_mode_q <= sleep_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit timing engine

    cbtm_bit_timer u_timer
    (
        .sys_clk              (sys_clk),
        .rst_n                (rst_n),
        .can_clk_en           (can_clk_en),
        .run                  (module_enable_q & ~init_active & ~sleep_active),
        .prescaler_field      (btr0_q[`CBTM_BTR0_BRP_HI:`CBTM_BTR0_BRP_LO]),
        .jump_width           (btr0_q[`CBTM_BTR0_SJW_HI:`CBTM_BTR0_SJW_LO]),
        .triple_sample_select (btr1_q[`CBTM_BTR1_TRIPLE_SAMPLE_SELECT]),
        .first_segment        (btr1_q[`CBTM_BTR1_FIRST_SEGMENT_HI:`CBTM_BTR1_FIRST_SEGMENT_LO]),
        .second_segment       (btr1_q[`CBTM_BTR1_SECOND_SEGMENT_HI:`CBTM_BTR1_SECOND_SEGMENT_LO]),
        .rx_sync              (rx_s),
        .tq_tick              (tq_tick),
        .bit_start            (bit_start),
        .bit_valid            (bit_valid),
        .bit_value            (bit_value)
    );

    assign reg_rd_data = rd_data_q;
    assign tx_pin      = tx_q;
    assign init_mode   = init_mode_q;
    assign sleep_mode  = sleep_mode_q;

endmodule

// ### include/cbtm_consts.svh
`ifndef CBTM_CONSTS_SVH
`define CBTM_CONSTS_SVH

// Register offsets on the byte-wide register port
`define CBTM_ADDR_W            5
`define CBTM_OFF_CTL0          5'h00
`define CBTM_OFF_CTL1          5'h01
`define CBTM_OFF_BTR0          5'h02
`define CBTM_OFF_BTR1          5'h03
`define CBTM_OFF_ACC_CTL       5'h04
`define CBTM_OFF_ACC_CODE      5'h08
`define CBTM_OFF_ACC_MASK      5'h10
`define CBTM_ACC_REGS          8

// Mode control register fields
`define CBTM_CTL0_INIT_REQ     0
`define CBTM_CTL0_SLEEP_REQ    1
`define CBTM_CTL0_WAKE_EN      2
`define CBTM_CTL0_WAKE_FLAG    7

// Control register one fields
`define CBTM_CTL1_ENABLE       7
`define CBTM_CTL1_CLK_SEL      6
`define CBTM_CTL1_WAKE_FILT    2
`define CBTM_CTL1_SLEEP_ACK    1
`define CBTM_CTL1_INIT_ACK     0

// Bit timing fields
`define CBTM_BTR0_SJW_HI       7
`define CBTM_BTR0_SJW_LO       6
`define CBTM_BTR0_BRP_HI       5
`define CBTM_BTR0_BRP_LO       0
`define CBTM_BTR1_TRIPLE_SAMPLE_SELECT         7
`define CBTM_BTR1_SECOND_SEGMENT_HI     6
`define CBTM_BTR1_SECOND_SEGMENT_LO     4
`define CBTM_BTR1_FIRST_SEGMENT_HI     3
`define CBTM_BTR1_FIRST_SEGMENT_LO     0

// Reset values
`define CBTM_RST_CTL0          8'h01
`define CBTM_RST_CTL1_WR       8'h00
`define CBTM_RST_BTR0          8'h00
`define CBTM_RST_BTR1          8'h00
`define CBTM_RST_ACC           8'h00

// Timing
`define CBTM_SYS_PERIOD_NS     20
`define CBTM_WAKE_PULSE_NS     2000
`define CBTM_WAKE_PULSE_CYC    ((`CBTM_WAKE_PULSE_NS + `CBTM_SYS_PERIOD_NS - 1) / `CBTM_SYS_PERIOD_NS)

`endif

// ### include/cbtm_pkg.sv
package cbtm_pkg;

    typedef enum logic [1:0]
    {
        SEG_SYNC,
        SEG_FIRST,
        SEG_SECOND
    } cbtm_seg_t;

    typedef logic [7:0] cbtm_byte_t;

endpackage

// ### logic/cbtm_bit_timer.sv
`include "cbtm_consts.svh"

module cbtm_bit_timer
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       can_clk_en,
    input  wire logic       run,
    input  wire logic [5:0] prescaler_field,
    input  wire logic [1:0] jump_width,
    input  wire logic       triple_sample_select,
    input  wire logic [3:0] first_segment,
    input  wire logic [2:0] second_segment,
    input  wire logic       rx_sync,
    output logic            tq_tick,
    output logic            bit_start,
    output logic            bit_valid,
    output logic            bit_value
);
    import cbtm_pkg::*;

    logic [5:0] pre_q;
    logic       tq_q;
    cbtm_seg_t  seg_q;
    logic [4:0] cnt_q;
    logic [4:0] ext_q;
    logic       rx_prev_q;
    logic [1:0] triple_sample_select_q;
    logic       start_q;
    logic       valid_q;
    logic       value_q;

    logic [4:0] sjw_len;
    logic [4:0] seg1_len;
    logic [4:0] seg2_len;
    logic [4:0] cnt_inc;
    logic       fall_edge;
    logic       majority;

    ////////////////////////////////////////////////////////////////////////////
    // Time quantum prescaler

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_q <= 6'h00;
            tq_q  <= 1'b0;
        end
        else if (!run)
        begin
            pre_q <= 6'h00;
            tq_q  <= 1'b0;
        end
        else
        begin
            tq_q <= 1'b0;
            if (can_clk_en)
            begin
                if (pre_q == 6'h00)
                begin
                    pre_q <= prescaler_field;
                    tq_q  <= 1'b1;
                end
                else
                begin
                    pre_q <= pre_q - 6'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Segment sequencer and sampling

    assign sjw_len   = {3'h0, jump_width} + 5'h01;
    assign seg1_len  = {1'h0, first_segment} + 5'h01;
    assign seg2_len  = {2'h0, second_segment} + 5'h01;
    assign cnt_inc   = cnt_q + 5'h01;
    assign fall_edge = rx_prev_q & ~rx_sync;
    assign majority  = (triple_sample_select_q[1] & triple_sample_select_q[0]) | (triple_sample_select_q[1] & rx_sync) | (triple_sample_select_q[0] & rx_sync);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seg_q     <= SEG_SYNC;
            cnt_q     <= 5'h00;
            ext_q     <= 5'h00;
            rx_prev_q <= 1'b1;
            triple_sample_select_q    <= 2'h3;
            start_q   <= 1'b0;
            valid_q   <= 1'b0;
            value_q   <= 1'b1;
        end
        else if (!run)
        begin
            seg_q     <= SEG_SYNC;
            cnt_q     <= 5'h00;
            ext_q     <= 5'h00;
            rx_prev_q <= 1'b1;
            start_q   <= 1'b0;
            valid_q   <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            valid_q <= 1'b0;
            if (tq_q)
            begin
                rx_prev_q <= rx_sync;
                triple_sample_select_q    <= {triple_sample_select_q[0], rx_sync};
                case (seg_q)
                    SEG_SYNC:
                    begin
                        seg_q   <= SEG_FIRST;
                        cnt_q   <= 5'h00;
                        ext_q   <= 5'h00;
                        start_q <= 1'b1;
                    end
                    SEG_FIRST:
                    begin
                        // Late edge: stretch the first segment, capped by jump width
                        if (fall_edge && ext_q == 5'h00 && cnt_q != 5'h00)
                        begin
                            ext_q <= (cnt_q < sjw_len) ? cnt_q : sjw_len;
                        end
                        if (cnt_inc >= seg1_len + ext_q)
                        begin
                            seg_q   <= SEG_SECOND;
                            cnt_q   <= 5'h00;
                            valid_q <= 1'b1;
                            value_q <= triple_sample_select ? majority : rx_sync;
                        end
                        else
                        begin
                            cnt_q <= cnt_inc;
                        end
                    end
                    SEG_SECOND:
                    begin
                        // Early edge ends the bit now when within jump width
                        if (fall_edge && (seg2_len - cnt_q) <= sjw_len)
                        begin
                            seg_q   <= SEG_FIRST;
                            cnt_q   <= 5'h00;
                            ext_q   <= 5'h00;
                            start_q <= 1'b1;
                        end
                        else if (cnt_inc >= seg2_len)
                        begin
                            seg_q <= SEG_SYNC;
                            cnt_q <= 5'h00;
                        end
                        else
                        begin
                            cnt_q <= cnt_inc;
                        end
                    end
                    default:
                    begin
                        seg_q <= SEG_SYNC;
                        cnt_q <= 5'h00;
                    end
                endcase
            end
        end
    end

    assign tq_tick   = tq_q;
    assign bit_start = start_q;
    assign bit_valid = valid_q;
    assign bit_value = value_q;

endmodule

// ### verification/cbtm_ctrl_properties.sv
`include "cbtm_consts.svh"

module cbtm_ctrl_checker
(
    input wire logic                    sys_clk,
    input wire logic                    rst_n,
    input wire logic [`CBTM_ADDR_W-1:0] reg_addr,
    input wire cbtm_pkg::cbtm_byte_t    reg_wr_data,
    input wire logic                    reg_wr_en,
    input wire logic                    reg_rd_en,
    input wire cbtm_pkg::cbtm_byte_t    reg_rd_data,
    input wire logic                    osc_clk_pin,
    input wire logic                    rx_pin,
    input wire logic                    tx_pin,
    input wire logic                    init_mode,
    input wire logic                    sleep_mode,
    input wire logic                    tq_tick,
    input wire logic                    bit_start,
    input wire logic                    bit_valid,
    input wire logic                    bit_value
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    a_rd_idle: assert property (!$past(reg_rd_en) |-> reg_rd_data == 8'h00)
        else $error("read data not zero outside read");
    a_tx_recessive: assert property (tx_pin)
        else $error("transmit pin left recessive level");
    a_valid_pulse: assert property (bit_valid |=> !bit_valid)
        else $error("sample pulse longer than one cycle");
    a_value_hold: assert property (!bit_valid |-> $stable(bit_value))
        else $error("bit value moved without sample pulse");
    a_init_quiet: assert property (init_mode && $past(init_mode) |-> !bit_valid && !bit_start)
        else $error("bit timer active in init mode");
    a_init_tick: assert property (init_mode && $past(init_mode) |-> !tq_tick)
        else $error("quantum tick in init mode");
    a_sleep_quiet: assert property (sleep_mode && $past(sleep_mode) |-> !bit_valid)
        else $error("bit timer active in sleep mode");
    // Sleep may end only by bus activity or a software write
    a_wake_cause: assert property ($fell(sleep_mode) |-> !$past(rx_pin, 2) || !$past(rx_pin, 3)
        || !$past(rx_pin, 4) || !$past(rx_pin, 5) || $past(reg_wr_en) || $past(reg_wr_en, 2)
        || $past(reg_wr_en, 3))
        else $error("sleep ended without cause");
endmodule

bind cbtm_ctrl cbtm_ctrl_checker u_chk (.sys_clk, .rst_n, .reg_addr, .reg_wr_data, .reg_wr_en,
    .reg_rd_en, .reg_rd_data, .osc_clk_pin, .rx_pin, .tx_pin, .init_mode, .sleep_mode, .tq_tick,
    .bit_start, .bit_valid, .bit_value);

// ### verification/cbtm_bus_model.sv
module cbtm_bus_model
(
    input wire logic sys_clk,
    output logic     osc_clk_pin,
    output logic     rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Oscillator runs free at 5 MHz, well below a quarter of the system clock
    initial
    begin
        osc_clk_pin = 1'b0;
        rx_pin = 1'b1;
        forever #100 osc_clk_pin = ~osc_clk_pin;
    end
    // Dominant pulse of n system cycles, then back to recessive idle
    task dom(input int n);
        @(posedge sys_clk);
        rx_pin <= 1'b0;
        repeat (n) @(posedge sys_clk);
        rx_pin <= 1'b1;
    endtask
endmodule

// ### verification/cbtm_ctrl_tb_top.sv
`include "cbtm_consts.svh"

module cbtm_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cbtm_pkg::*;
    logic                    sys_clk, rst_n, reg_wr_en, reg_rd_en, osc_clk_pin, rx_pin;
    logic [`CBTM_ADDR_W-1:0] reg_addr;
    cbtm_byte_t              reg_wr_data, reg_rd_data, d;
    logic                    tx_pin, init_mode, sleep_mode, tq_tick, bit_start, bit_valid;
    logic                    bit_value;
    int                      n_errors, cmp_count, cyc, t0, t1;
    cbtm_ctrl dut (.sys_clk, .rst_n, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en,
        .reg_rd_data, .osc_clk_pin, .rx_pin, .tx_pin, .init_mode, .sleep_mode, .tq_tick,
        .bit_start, .bit_valid, .bit_value);
    cbtm_bus_model bus (.sys_clk, .osc_clk_pin, .rx_pin);
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end
    task chk(input string nm, input cbtm_byte_t seen, input cbtm_byte_t exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [`CBTM_ADDR_W-1:0] a, input cbtm_byte_t v);
        @(posedge sys_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= v;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
    endtask
    task rd(input logic [`CBTM_ADDR_W-1:0] a, output cbtm_byte_t v);
        @(posedge sys_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        #1 v = reg_rd_data;
    endtask
    // Bounded wait for a bit start pulse, returns the cycle it was seen in
    task wait_bs(output int t);
        t = -1;
        for (int i = 0; i < 300 && t < 0; i++)
        begin
            @(posedge sys_clk);
            #1 if (bit_start === 1'b1) t = cyc;
        end
    endtask
    task print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = '0;
        {n_errors, cmp_count, cyc} = '0;
        rst_n = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Clear of init request before acknowledge must be dropped
        wr(`CBTM_OFF_CTL0, 8'h00);
        repeat (30) @(posedge sys_clk);
        rd(`CBTM_OFF_CTL0, d);
        chk("init_request", d & 8'h01, 8'h01);
        rd(`CBTM_OFF_CTL1, d);
        chk("init_ack", d & 8'h03, 8'h01);
        chk("init_mode", {7'h00, init_mode}, 8'h01);
        $display("test init done");
        // Enable, bus clock, filtered wake; P=2, first 4 Tq, second 3 Tq
        wr(`CBTM_OFF_CTL1, 8'hC7);
        wr(`CBTM_OFF_BTR0, 8'h41);
        wr(`CBTM_OFF_BTR1, 8'h23);
        rd(`CBTM_OFF_CTL1, d);
        chk("ctl1", d, 8'hC5);
        rd(`CBTM_OFF_BTR0, d);
        chk("btr0", d, 8'h41);
        rd(`CBTM_OFF_BTR1, d);
        chk("btr1", d, 8'h23);
        wr(`CBTM_OFF_CTL0, 8'h00);
        wait_bs(t0);
        wait_bs(t1);
        chk("bit_period", 8'(t1 - t0), 8'h10);
        chk("bit_value", {7'h00, bit_value}, 8'h01);
        wr(`CBTM_OFF_BTR0, 8'hFF);
        rd(`CBTM_OFF_BTR0, d);
        chk("btr0_locked", d, 8'h41);
        $display("test timing done");
        wr(`CBTM_OFF_CTL0, 8'h06);
        repeat (10) @(posedge sys_clk);
        rd(`CBTM_OFF_CTL1, d);
        chk("sleep_ack", d & 8'h02, 8'h02);
        chk("sleep_mode", {7'h00, sleep_mode}, 8'h01);
        bus.dom(40);
        repeat (10) @(posedge sys_clk);
        chk("short_pulse", {7'h00, sleep_mode}, 8'h01);
        bus.dom(150);
        repeat (10) @(posedge sys_clk);
        chk("woken", {7'h00, sleep_mode}, 8'h00);
        rd(`CBTM_OFF_CTL0, d);
        chk("wake_flag", d & 8'h82, 8'h80);
        rd(`CBTM_OFF_CTL1, d);
        chk("ack_clear", d & 8'h02, 8'h00);
        $display("test sleep done");
        // Unfiltered wake, triple sampling with a first segment of 4 Tq
        wr(`CBTM_OFF_CTL0, 8'h05);
        repeat (5) @(posedge sys_clk);
        wr(`CBTM_OFF_CTL1, 8'hC3);
        wr(`CBTM_OFF_BTR1, 8'hA3);
        wr(`CBTM_OFF_CTL0, 8'h04);
        fork
            bus.dom(60);
            begin
                repeat (40) @(posedge sys_clk);
                #1 chk("majority", {7'h00, bit_value}, 8'h00);
            end
        join
        wr(`CBTM_OFF_CTL0, 8'h02);
        repeat (5) @(posedge sys_clk);
        bus.dom(3);
        repeat (10) @(posedge sys_clk);
        chk("no_wake", {7'h00, sleep_mode}, 8'h01);
        wr(`CBTM_OFF_CTL0, 8'h06);
        bus.dom(3);
        repeat (10) @(posedge sys_clk);
        chk("any_dominant", {7'h00, sleep_mode}, 8'h00);
        $display("test wake modes done");
        print_verdict();
    end
endmodule
